// >>> rtl/hpcfg_bank.sv
// Register slice holding hub current budgets, port settle time, language id, string length.
// Assumes a synchronous byte register port; descriptor logic samples desc_out.
`timescale 1ns/1ps
module hpcfg_bank
    import hpcfg_pkg::*;
#(
    // Settle unit length in clock cycles; a short unit keeps simulation quick.
    parameter int UNIT_CYC = HPCFG_UNIT_CYC
)
(
    // Clock, reset and enable.
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        clk_en_in,
    // Register port.
    input  wire hpcfg_req_s  req_in,
    output logic [7:0]       rdata_out,
    output logic             rvalid_out,
    // Power mode, high when self-powered.
    input  wire logic        self_powered_in,
    // Descriptor values for the upstream host.
    output hpcfg_desc_s      desc_out,
    // Port power-on settle timer.
    input  wire logic        port_pwr_start_in,
    output logic             port_pwr_stable_out
);
    logic [7:0]  regs_q [8];
    logic [2:0]  idx;
    logic        hit;
    logic [7:0]  settle_left_q;
    logic [31:0] unit_cnt_q;
    logic        settle_busy_q;

    assign hit = (req_in.addr >= HPCFG_OFS_SP_HUB) && (req_in.addr <= HPCFG_OFS_MFR_LEN);
    assign idx = 3'(req_in.addr - HPCFG_OFS_SP_HUB);

    // storage, plain 2 mA and 2 ms counts.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_reg
            localparam logic [7:0] RST = ((g == 1) || (g == 3)) ? HPCFG_RST_BP : HPCFG_RST_ZERO;
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    regs_q[g] <= RST;
                end else if (clk_en_in && req_in.wr && hit && (idx == 3'(g))) begin
                    regs_q[g] <= req_in.wdata;
                end
            end
        end
    endgenerate

    // Reads answer one cycle later; unmapped offsets read zero.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out  <= HPCFG_RST_ZERO;
            rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            rvalid_out <= req_in.rd;
            rdata_out  <= (req_in.rd && hit) ? regs_q[idx] : HPCFG_UNMAPPED_RD;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            desc_out <= '0;
        end else if (clk_en_in) begin
            desc_out.hub_ma2    <= self_powered_in ? regs_q[0] : regs_q[1];
            desc_out.ctl_ma2    <= self_powered_in ? regs_q[2] : regs_q[3];
            desc_out.settle_ms2 <= regs_q[4];
            desc_out.lang_id    <= {regs_q[5], regs_q[6]};
            desc_out.mfr_len    <= regs_q[7];
        end
    end

    // settle timer in 2 ms units.
    // A zero setting reports stable two cycles after the start pulse, one edge after the load.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            settle_left_q       <= HPCFG_RST_ZERO;
            unit_cnt_q          <= '0;
            settle_busy_q       <= 1'b0;
            port_pwr_stable_out <= 1'b0;
        end else if (clk_en_in) begin
            if (port_pwr_start_in) begin
                settle_left_q       <= regs_q[4];
                unit_cnt_q          <= '0;
                settle_busy_q       <= 1'b1;
                port_pwr_stable_out <= 1'b0;
            end else if (settle_busy_q) begin
                if (settle_left_q == 8'h00) begin
                    settle_busy_q       <= 1'b0;
                    port_pwr_stable_out <= 1'b1;
                end else if (unit_cnt_q == 32'(UNIT_CYC - 1)) begin
                    unit_cnt_q    <= '0;
                    settle_left_q <= settle_left_q - 8'h01;
                end else begin
                    unit_cnt_q <= unit_cnt_q + 32'h1;
                end
            end
        end
    end

    // string span in bytes.
    // Each character is one 16-bit UTF-16LE code unit, low byte at the lower address,
    // so the string area spans twice the character count in bytes.
    logic [8:0] mfr_span_q;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mfr_span_q <= 9'h000;
        end else if (clk_en_in) begin
            mfr_span_q <= {regs_q[7], 1'b0};
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // The two bus-powered reset values are checked on the first edge after every release, mid-run ones too.
    property p_bp_hub_reset;
        $fell(rst_in) |-> regs_q[1] == HPCFG_RST_BP;
    endproperty
    a_bp_hub_reset: assert property (p_bp_hub_reset)
        else $error("bus hub budget reset wrong");

    property p_bp_ctl_reset;
        $fell(rst_in) |-> regs_q[3] == HPCFG_RST_BP;
    endproperty
    a_bp_ctl_reset: assert property (p_bp_ctl_reset)
        else $error("bus ctl current reset wrong");

    property p_lang_order;
        clk_en_in |=> desc_out.lang_id == {$past(regs_q[5]), $past(regs_q[6])};
    endproperty
    a_lang_order: assert property (p_lang_order)
        else $error("language id byte order wrong");

    property p_mode_sel;
        clk_en_in && self_powered_in |=> desc_out.hub_ma2 == $past(regs_q[0]);
    endproperty
    a_mode_sel: assert property (p_mode_sel)
        else $error("self mode hub budget wrong");

    property p_mode_bus;
        clk_en_in && !self_powered_in |=> desc_out.ctl_ma2 == $past(regs_q[3]);
    endproperty
    a_mode_bus: assert property (p_mode_bus)
        else $error("bus mode ctl current wrong");

    // Writes land on the edge that takes them; off-map writes must not alias a register.
    property p_write_hub;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_SP_HUB
            |=> regs_q[0] == $past(req_in.wdata);
    endproperty
    a_write_hub: assert property (p_write_hub)
        else $error("self hub budget write lost");

    property p_write_ctl;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_SP_CTL
            |=> regs_q[2] == $past(req_in.wdata);
    endproperty
    a_write_ctl: assert property (p_write_ctl)
        else $error("self ctl current write lost");

    property p_write_bp;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_BP_HUB
            |=> regs_q[1] == $past(req_in.wdata);
    endproperty
    a_write_bp: assert property (p_write_bp)
        else $error("bus hub budget write lost");

    property p_write_bp_ctl;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_BP_CTL
            |=> regs_q[3] == $past(req_in.wdata);
    endproperty
    a_write_bp_ctl: assert property (p_write_bp_ctl)
        else $error("bus ctl current write lost");

    property p_write_settle;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_SETTLE
            |=> regs_q[4] == $past(req_in.wdata);
    endproperty
    a_write_settle: assert property (p_write_settle)
        else $error("settle time write lost");

    property p_write_lang_up;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_LANG_UP
            |=> regs_q[5] == $past(req_in.wdata);
    endproperty
    a_write_lang_up: assert property (p_write_lang_up)
        else $error("language upper write lost");

    property p_write_lang_lo;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_LANG_LO
            |=> regs_q[6] == $past(req_in.wdata);
    endproperty
    a_write_lang_lo: assert property (p_write_lang_lo)
        else $error("language lower write lost");

    property p_write_len;
        clk_en_in && req_in.wr && req_in.addr == HPCFG_OFS_MFR_LEN
            |=> regs_q[7] == $past(req_in.wdata);
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("text length write lost");

    property p_off_map_hold;
        clk_en_in && req_in.wr && (req_in.addr < HPCFG_OFS_SP_HUB || req_in.addr > HPCFG_OFS_MFR_LEN)
            |=> $stable(regs_q[0]) && $stable(regs_q[7]);
    endproperty
    a_off_map_hold: assert property (p_off_map_hold)
        else $error("off map write changed a register");

    property p_self_ctl;
        clk_en_in && self_powered_in |=> desc_out.ctl_ma2 == $past(regs_q[2]);
    endproperty
    a_self_ctl: assert property (p_self_ctl)
        else $error("self mode ctl current wrong");

    property p_bus_hub;
        clk_en_in && !self_powered_in |=> desc_out.hub_ma2 == $past(regs_q[1]);
    endproperty
    a_bus_hub: assert property (p_bus_hub)
        else $error("bus mode hub budget wrong");

    property p_settle_copy;
        clk_en_in |=> desc_out.settle_ms2 == $past(regs_q[4]);
    endproperty
    a_settle_copy: assert property (p_settle_copy)
        else $error("settle time descriptor wrong");

    property p_len_copy;
        clk_en_in |=> desc_out.mfr_len == $past(regs_q[7]);
    endproperty
    a_len_copy: assert property (p_len_copy)
        else $error("text length descriptor wrong");

    property p_span;
        clk_en_in |=> mfr_span_q == 9'($past(regs_q[7])) + 9'($past(regs_q[7]));
    endproperty
    a_span: assert property (p_span)
        else $error("string byte span wrong");

    // A low clock enable must freeze every output, not only the registers.
    property p_freeze;
        !clk_en_in
            |=> $stable(desc_out) && $stable(rdata_out) && $stable(rvalid_out);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("outputs moved while disabled");

    property p_timer_freeze;
        !clk_en_in |=> $stable(port_pwr_stable_out) && $stable(settle_left_q);
    endproperty
    a_timer_freeze: assert property (p_timer_freeze)
        else $error("settle timer moved while disabled");

    // The timer restarts on every start pulse, even one that arrives mid-count.
    property p_settle_zero;
        clk_en_in && port_pwr_start_in && regs_q[4] == 8'h00
            ##1 clk_en_in && !port_pwr_start_in |=> port_pwr_stable_out;
    endproperty
    a_settle_zero: assert property (p_settle_zero)
        else $error("zero settle not immediate");

    property p_start_clears;
        clk_en_in && port_pwr_start_in
            |=> !port_pwr_stable_out && settle_left_q == $past(regs_q[4]);
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not reload the timer");

    property p_not_early;
        settle_busy_q && settle_left_q != 8'h00 |-> !port_pwr_stable_out;
    endproperty
    a_not_early: assert property (p_not_early)
        else $error("port reported stable too early");

    property p_unit_step;
        clk_en_in && !port_pwr_start_in && settle_busy_q && settle_left_q != 8'h00
            && unit_cnt_q == 32'(UNIT_CYC - 1)
            |=> settle_left_q == $past(settle_left_q) - 8'h01;
    endproperty
    a_unit_step: assert property (p_unit_step)
        else $error("settle unit step wrong");

    property p_stable_hold;
        port_pwr_stable_out && !(clk_en_in && port_pwr_start_in)
            |=> port_pwr_stable_out;
    endproperty
    a_stable_hold: assert property (p_stable_hold)
        else $error("stable dropped without a start");

    property p_read_back;
        clk_en_in && req_in.rd && req_in.addr == HPCFG_OFS_MFR_LEN
            |=> rvalid_out && rdata_out == $past(regs_q[7]);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("length read back wrong");

    c_self_mode: cover property (clk_en_in && self_powered_in);
    c_settle_done: cover property ($rose(port_pwr_stable_out));
    c_lang_write: cover property (req_in.wr && req_in.addr == HPCFG_OFS_LANG_UP);
    c_settle_zero: cover property (clk_en_in && port_pwr_start_in && regs_q[4] == 8'h00);
    c_frozen_write: cover property (!clk_en_in && req_in.wr);
endmodule

// >>> rtl/hpcfg_pkg.sv
// Constants and carrier types for the hub power and language configuration slice.
// Assumes a byte-wide register port driven by the configuration loader (EEPROM or SMBus).
package hpcfg_pkg;
    localparam logic [7:0] HPCFG_OFS_SP_HUB   = 8'h0C;
    localparam logic [7:0] HPCFG_OFS_BP_HUB   = 8'h0D;
    localparam logic [7:0] HPCFG_OFS_SP_CTL   = 8'h0E;
    localparam logic [7:0] HPCFG_OFS_BP_CTL   = 8'h0F;
    localparam logic [7:0] HPCFG_OFS_SETTLE   = 8'h10;
    localparam logic [7:0] HPCFG_OFS_LANG_UP  = 8'h11;
    localparam logic [7:0] HPCFG_OFS_LANG_LO  = 8'h12;
    localparam logic [7:0] HPCFG_OFS_MFR_LEN  = 8'h13;
    localparam logic [7:0] HPCFG_RST_ZERO     = 8'h00;
    localparam logic [7:0] HPCFG_RST_BP       = 8'h32;
    localparam logic [7:0] HPCFG_UNMAPPED_RD  = 8'h00;
    localparam int         HPCFG_UNIT_MA      = 2;
    localparam int         HPCFG_UNIT_MS      = 2;
    localparam int         HPCFG_CLK_MHZ      = 40;
    localparam int         HPCFG_UNIT_CYC     = HPCFG_UNIT_MS * 1000 * HPCFG_CLK_MHZ;
    localparam logic [7:0] HPCFG_SP_LIMIT     = 8'h32;
    localparam logic [7:0] HPCFG_STR_LIMIT    = 8'h1F;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpcfg_req_s;

    typedef struct packed {
        logic [7:0]  hub_ma2;
        logic [7:0]  ctl_ma2;
        logic [7:0]  settle_ms2;
        logic [15:0] lang_id;
        logic [7:0]  mfr_len;
    } hpcfg_desc_s;
endpackage

// >>> verification/hpcfg_bank_test.sv
// Self-checking bench for the hub power and language register slice.
// Assumes the settle unit is shortened through UNIT_CYC.
`timescale 1ns/1ps
module hpcfg_bank_test;
    import hpcfg_pkg::*;
    localparam int UNIT = 4;
    logic        clock_in, rst_in, clk_en_in, self_powered_in, start, stable, rvalid;
    logic [7:0]  rdata;
    hpcfg_req_s  req;
    hpcfg_desc_s desc;
    logic [7:0]  val [8] = '{8'h32, 8'h7A, 8'h19, 8'h2C, 8'h03, 8'h04, 8'h09, 8'h1F};
    int          n_mismatch = 0;
    int          samples_checked = 0;
    hpcfg_bank #(.UNIT_CYC(UNIT)) dut (.clock_in(clock_in), .rst_in(rst_in),
        .clk_en_in(clk_en_in), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
        .self_powered_in(self_powered_in), .desc_out(desc),
        .port_pwr_start_in(start), .port_pwr_stable_out(stable));
    hpcfg_host_model host (.clock_in(clock_in), .stable_in(stable), .start_out(start));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Requests are left standing; the next task or idle replaces them.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_in);
        #1;
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_in);
        #1 chk("rvalid", 16'h0001, {15'h0, rvalid});
        chk("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic idle();
        req = '0;
        repeat (2) @(posedge clock_in);
        #1;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'h0C + 8'(i), (i == 1 || i == 3) ? 8'h32 : 8'h00);
        end
        idle();
        chk("hub bus", 16'h0032, {8'h00, desc.hub_ma2});
        $display("test reset done");
    endtask
    task automatic t_write();
        for (int i = 0; i < 8; i++) wr(8'h0C + 8'(i), val[i]);
        for (int i = 0; i < 8; i++) rd_chk(8'h0C + 8'(i), val[i]);
        wr(8'h14, 8'hAA);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h0B, 8'h00);
        idle();
        $display("test write done");
    endtask
    task automatic t_desc();
        chk("hub bus", 16'h007A, {8'h00, desc.hub_ma2});
        chk("ctl bus", 16'h002C, {8'h00, desc.ctl_ma2});
        self_powered_in = 1'b1;
        idle();
        chk("hub self", 16'h0032, {8'h00, desc.hub_ma2});
        chk("ctl self", 16'h0019, {8'h00, desc.ctl_ma2});
        chk("lang", 16'h0409, desc.lang_id);
        chk("settle", 16'h0003, {8'h00, desc.settle_ms2});
        chk("mfr len", 16'h001F, {8'h00, desc.mfr_len});
        $display("test desc done");
    endtask
    task automatic t_settle();
        int cyc;
        host.power_on(cyc);
        chk("settle window", 16'h0001, {15'h0, cyc >= 3 * UNIT && cyc <= 3 * UNIT + 3});
        wr(HPCFG_OFS_SETTLE, 8'h00);
        idle();
        host.power_on(cyc);
        chk("zero settle", 16'h0001, {15'h0, cyc <= 2});
        $display("test settle done");
    endtask
    task automatic t_freeze();
        clk_en_in = 1'b0;
        wr(HPCFG_OFS_SP_HUB, 8'h11);
        idle();
        clk_en_in = 1'b1;
        rd_chk(HPCFG_OFS_SP_HUB, 8'h32);
        idle();
        $display("test freeze done");
    endtask
    task automatic t_rerst();
        rst_in = 1'b1;
        #1 chk("stable in reset", 16'h0000, {15'h0, stable});
        repeat (2) @(posedge clock_in);
        #1 rst_in = 1'b0;
        rd_chk(HPCFG_OFS_BP_HUB, HPCFG_RST_BP);
        rd_chk(HPCFG_OFS_BP_CTL, HPCFG_RST_BP);
        rd_chk(HPCFG_OFS_SP_HUB, 8'h00);
        idle();
        chk("hub self reset", 16'h0000, {8'h00, desc.hub_ma2});
        $display("test mid reset done");
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk_en_in = 1'b1;
        rst_in = 1'b1;
        req = '0;
        self_powered_in = 1'b0;
        repeat (10) @(posedge clock_in);
        #1 rst_in = 1'b0;
        t_reset();
        t_write();
        t_desc();
        t_freeze();
        t_settle();
        t_rerst();
        close_out();
    end
    initial begin
        #(25 * 2000);
        n_mismatch++;
        close_out();
    end
endmodule

// >>> verification/hpcfg_host_model.sv
// Upstream host model: starts a port power-on and times the settle.
// Assumes it shares the bank clock and sees a registered stable level.
`timescale 1ns/1ps
module hpcfg_host_model (
    // Clock.
    input  wire logic clock_in,
    // Port power handshake.
    input  wire logic stable_in,
    output logic      start_out
);
    initial start_out = 1'b0;
    task automatic power_on(output int cyc);
        @(posedge clock_in);
        #1 start_out = 1'b1;
        @(posedge clock_in);
        #1 start_out = 1'b0;
        cyc = 1;
        while (stable_in !== 1'b1 && cyc < 200) begin
            @(posedge clock_in);
            #1 cyc++;
        end
    endtask
endmodule
